// >>> rtl/dmc_regs.sv
/*
 Upper mode-control register bank of a stereo converter, reached over a
 16-bit serial control port (select, bit clock, data in, data out).
 Assumes the port clock is a separate domain that idles between frames,
 and that zero detection and sample paths live elsewhere on clk.
*/
module dmc_regs
    import dmc_pkg::*;
#(
    parameter logic [4:0] LINK_ID = 5'h00  // Arbitrary neutral identifier
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       port_clk,
    input  wire logic       port_sel_n,
    input  wire logic       port_din,
    output logic            port_dout,
    output logic            port_dout_oe_n,
    input  wire logic       left_zero_det,
    input  wire logic       right_zero_det,
    input  wire logic       in_bitstream_sel,
    output logic            left_zero_pin,
    output logic            right_zero_pin,
    output logic            system_reset,
    output logic            rolloff_select,
    output logic            analog_mute,
    output logic            bitstream_mode,
    output logic            filter_bypass,
    output logic            single_channel_mode,
    output logic            single_channel_source,
    output logic [1:0]      modulator_rate,
    output logic [1:0]      bitstream_clock_rate,
    output logic [1:0]      bitstream_zero_select,
    output dmc_pkg::dmc_src_t sample_source
);
    import dmc_pkg::*;

    // Timing notes for the control port and its crossing into clk.
    //
    // Frame shape
    //   Select falls, then sixteen port clock cells follow, MSB first.
    //   Each bit is taken on the rising port clock edge.
    //   Select rises again once the last cell has ended.
    //   The port clock stands still between frames.
    //
    // Why the port side clears asynchronously
    //   No port clock edge arrives while select is high.
    //   A clocked clear of the counter would therefore never run.
    //   The counter and the read flag clear on select high instead.
    //   System reset clears them as well, so they are never unknown.
    //   Every asynchronous branch loads constants only.
    //
    // Write path
    //   The sixteenth rising edge copies the whole word into a holder.
    //   The same edge flips a toggle that crosses into clk.
    //   The toggle passes two flops before the edge detector reads it.
    //   The holder is not synchronised bit by bit.
    //   It stands still from its load until the next frame's last bit.
    //   By the time the toggle edge is seen, it has long settled.
    //   The write then lands two to three clk cycles after the edge.
    //   Mode outputs follow one clk cycle after the register.
    //
    // Read path
    //   The header byte holds the read flag and the register index.
    //   The index is taken from the live shifter on clk.
    //   The read mux is combinational after the index register.
    //   So the readback byte settles within one clk cycle of the index.
    //   The port side loads it on the falling edge after the header.
    //   Half a port cell is two clk cycles, which leaves one in hand.
    //   Later falling edges shift it out one bit per cell.
    //   The outgoing bit crosses back into clk through two flops.
    //   The host must therefore sample late in each cell.
    //   A port clock slower than three clk periods per cell is needed.
    //
    // Limitations
    //   Back-to-back frames need a few clk cycles between them.
    //   Otherwise two toggle flips could merge before clk sees them.
    //   Readback lags the port clock by up to three clk cycles.
    //   The echo on the left zero pin carries the same lag.
    //
    // Soft reset
    //   A write of one to the reset bit raises a one-cycle pulse.
    //   The pulse restores the stored fields to their defaults.
    //   The reset bit itself is never stored, so it reads as zero.
    //   A later write of one gives a fresh pulse.
    //
    // Zero flags
    //   The detector decides what counts as zero for each mode.
    //   This bank only gates the flags by the per-mode enables.
    //   Status bits mirror the zero pins unless echo takes the left pin.
    //
    // Reserved positions
    //   Writes to reserved positions are dropped on the way in.
    //   Reads of reserved positions return zero.
    //   Unknown indices read zero and ignore writes.

    // Register state, all on clk
    logic [3:0] filter_ctrl;
    logic [5:0] mode_sel;
    logic [2:0] zero_en;
    logic [1:0] zero_flags;

    // Port-domain shifter and frame bookkeeping
    logic [WORD_BITS-1:0] shift_in;
    logic [CNT_BITS-1:0]  bit_cnt;
    logic [7:0]           rd_shift;
    logic                 rd_active;
    logic                 word_toggle;
    logic [WORD_BITS-1:0] word_hold;

    // Readback word handed from clk to port domain
    logic [7:0]           rd_data;

    // Crossing into clk
    logic       tog_s1, tog_s2, tog_s3;
    logic       sel_s1, sel_s2;
    logic       ld_s1, ld_s2;
    logic       rd_s1, rd_s2;
    logic       echo_s1, echo_s2;

    // Port side idles on select high or system reset; the port clock
    // stops between frames, so a clocked clear would never happen
    logic port_idle;
    assign port_idle = port_sel_n | ~rstn;

    // Incoming bits shift on rising port clock
    always_ff @(posedge port_clk) begin
        if (!port_sel_n) begin
            shift_in <= {shift_in[WORD_BITS-2:0], port_din};
        end
    end

    // Bit counter, cleared while the port idles
    always_ff @(posedge port_clk or posedge port_idle) begin
        if (port_idle) begin
            bit_cnt <= '0;
        end else begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    // The last bit latches the word and flips the completion toggle;
    // the toggle must start known or no write would ever be seen
    always_ff @(posedge port_clk or negedge rstn) begin
        if (!rstn) begin
            word_toggle <= 1'b0;
            word_hold   <= '0;
        end else if (!port_sel_n && bit_cnt == LAST_BIT) begin
            word_hold   <= {shift_in[WORD_BITS-2:0], port_din};
            word_toggle <= ~word_toggle;
        end
    end

    // Readback: after the 8 header bits, shift out the selected register.
    // rd_data settles within a clk cycle of the index, before this edge.
    always_ff @(negedge port_clk or posedge port_idle) begin
        if (port_idle) begin
            rd_active <= 1'b0;
        end else if (bit_cnt == 5'(WORD_BITS - IDX_LO) &&
                     shift_in[DATA_HI] == 1'b1) begin
            rd_shift  <= rd_data;
            rd_active <= 1'b1;
        end else begin
            rd_shift <= {rd_shift[6:0], 1'b0};
        end
    end

    // Two-flop synchronisers for port signals sampled on clk
    always_ff @(posedge clk) begin
        tog_s1  <= word_toggle;
        tog_s2  <= tog_s1;
        tog_s3  <= tog_s2;
        sel_s1  <= port_sel_n;
        sel_s2  <= sel_s1;
        ld_s1   <= rd_shift[7];
        ld_s2   <= ld_s1;
        rd_s1   <= rd_active;
        rd_s2   <= rd_s1;
    end

    // Pending header index; live shift register is read on clk during every frame, write or read
    logic [6:0] rd_idx;
    always_ff @(posedge clk) begin
        echo_s1 <= shift_in[IDX_HI-1];
        echo_s2 <= echo_s1;
    end

    // Readback index is taken from the header byte, settled before use
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_idx <= 7'h00;
        end else if (sel_s2) begin
            rd_idx <= 7'h00;
        end else begin
            rd_idx <= 7'(shift_in[IDX_HI-IDX_LO:0]);
        end
    end

    // Read multiplexer; combinational so the byte is ready in time
    // for the falling edge that loads it. Reserved positions read zero.
    always_comb begin
        case (rd_idx)
            IDX_FILTER_CTRL: rd_data = {4'h0, filter_ctrl};
            IDX_MODE_SEL:    rd_data = {2'h0, mode_sel};
            IDX_ZERO_EN:     rd_data = {5'h00, zero_en};
            IDX_ZERO_STAT:   rd_data = {6'h00, zero_flags};
            IDX_LINK_ID:     rd_data = {3'h0, LINK_ID};
            default:         rd_data = 8'h00;
        endcase
    end

    // Word completion strobe on clk
    logic       word_evt;
    assign word_evt = tog_s2 ^ tog_s3;

    logic       wr_evt;
    logic [6:0] wr_idx;
    logic [7:0] wr_dat;
    assign wr_evt = word_evt && !word_hold[RW_BIT];
    assign wr_idx = word_hold[IDX_HI:IDX_LO];
    assign wr_dat = word_hold[DATA_HI:0];

    // Register 19 low nibble: echo, bypass stereo, rolloff, zero mute
    always_ff @(posedge clk) begin
        if (!rstn || system_reset) begin
            filter_ctrl <= RST_FILTER_CTRL;
        end else if (wr_evt && wr_idx == IDX_FILTER_CTRL) begin
            filter_ctrl <= wr_dat[3:0];
        end
    end

    // Mode select: soft reset is not stored, only pulsed
    always_ff @(posedge clk) begin
        if (!rstn || system_reset) begin
            mode_sel <= RST_MODE_SEL;
        end else if (wr_evt && wr_idx == IDX_MODE_SEL) begin
            mode_sel <= wr_dat[5:0];
        end
    end

    // One-cycle system reset pulse per write of one
    always_ff @(posedge clk) begin
        if (!rstn) begin
            system_reset <= 1'b0;
        end else begin
            system_reset <= wr_evt && wr_idx == IDX_MODE_SEL &&
                            wr_dat[F_SOFT_RESET];
        end
    end

    // Zero flag enables; reserved bits dropped
    always_ff @(posedge clk) begin
        if (!rstn || system_reset) begin
            zero_en <= RST_ZERO_EN;
        end else if (wr_evt && wr_idx == IDX_ZERO_EN) begin
            zero_en <= wr_dat[2:0];
        end
    end

    // Zero flags gated per mode; status mirrors pins.
    // Even-versus-96 pattern choice is done by the detector via the field.
    logic flags_on;
    assign flags_on = mode_sel[F_BITSTR] ?
                      (zero_en[F_BZ_HI:F_BZ_LO] != BZ_OFF) :
                      zero_en[F_PCM_ZERO_ENABLE];
    always_ff @(posedge clk) begin
        if (!rstn || system_reset) begin
            zero_flags <= 2'h0;
        end else begin
            zero_flags <= {flags_on & right_zero_det,
                           flags_on & left_zero_det};
        end
    end

    // Mode outputs registered from the bank
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rolloff_select        <= 1'b0;
            analog_mute           <= 1'b0;
            bitstream_mode        <= 1'b0;
            filter_bypass         <= 1'b0;
            single_channel_mode   <= 1'b0;
            single_channel_source <= 1'b0;
            modulator_rate        <= RATE_64X;
            bitstream_clock_rate  <= RATE_64X;
            bitstream_zero_select <= BZ_OFF;
            sample_source         <= DMC_SRC_PCM;
        end else begin
            rolloff_select        <= filter_ctrl[F_ROLLOFF];
            analog_mute           <= filter_ctrl[F_ZMUTE] &&
                                     !mode_sel[F_BITSTR] &&
                                     zero_flags == 2'h3;
            bitstream_mode        <= mode_sel[F_BITSTR];
            filter_bypass         <= mode_sel[F_BYPASS];
            single_channel_mode   <= mode_sel[F_SINGLE_CHANNEL_MODE];
            single_channel_source <= mode_sel[F_SINGLE_CHANNEL_MODE] &
                                     mode_sel[F_SINGLE_CHANNEL_MODE_SRC];
            // Rate field means modulator rate in PCM, bit clock otherwise
            modulator_rate        <= mode_sel[F_BITSTR] ? RATE_64X :
                                     mode_sel[F_RATE_HI:F_RATE_LO];
            bitstream_clock_rate  <= mode_sel[F_BITSTR] ?
                                     mode_sel[F_RATE_HI:F_RATE_LO] :
                                     RATE_64X;
            bitstream_zero_select <= zero_en[F_BZ_HI:F_BZ_LO];
            if (!mode_sel[F_BYPASS] || in_bitstream_sel)
                sample_source <= DMC_SRC_PCM;
            else if (filter_ctrl[F_BYP_STER])
                sample_source <= DMC_SRC_BITSTREAM_PAIR;
            else
                sample_source <= DMC_SRC_PARALLEL;
        end
    end

    // Pins: left pin carries echo when enabled, otherwise the zero flag
    always_ff @(posedge clk) begin
        if (!rstn) begin
            left_zero_pin  <= 1'b0;
            right_zero_pin <= 1'b0;
            port_dout      <= 1'b0;
            port_dout_oe_n <= 1'b1;
        end else begin
            left_zero_pin  <= filter_ctrl[F_ECHO_EN] ?
                              (rd_s2 & ld_s2) : zero_flags[F_ZL];
            right_zero_pin <= zero_flags[F_ZR];
            port_dout      <= rd_s2 & ld_s2;
            port_dout_oe_n <= ~(rd_s2 & !sel_s2);
        end
    end
endmodule // dmc_regs

// >>> rtl/dmc_pkg.sv
/*
 Constants for the mode-control register bank: control word layout,
 register indices, field positions, reset values and mode encodings.
 Assumes it is compiled before every design file that imports it.
*/
package dmc_pkg;
    // Control word layout
    localparam int WORD_BITS  = 16;
    localparam int RW_BIT     = 15;
    localparam int IDX_HI     = 14;
    localparam int IDX_LO     = 8;
    localparam int DATA_HI    = 7;
    localparam int CNT_BITS   = 5;
    localparam logic [4:0] LAST_BIT = 5'h0F;

    // Register indices (B14..B8)
    localparam logic [6:0] IDX_FILTER_CTRL = 7'h13;
    localparam logic [6:0] IDX_MODE_SEL    = 7'h14;
    localparam logic [6:0] IDX_ZERO_EN     = 7'h15;
    localparam logic [6:0] IDX_ZERO_STAT   = 7'h16;
    localparam logic [6:0] IDX_LINK_ID     = 7'h17;

    // Register 19 low nibble
    localparam int F_ECHO_EN  = 3;
    localparam int F_BYP_STER = 2;
    localparam int F_ROLLOFF  = 1;
    localparam int F_ZMUTE    = 0;
    // Mode select register
    localparam int F_SOFT_RESET     = 6;
    localparam int F_BITSTR   = 5;
    localparam int F_BYPASS   = 4;
    localparam int F_SINGLE_CHANNEL_MODE     = 3;
    localparam int F_SINGLE_CHANNEL_MODE_SRC = 2;
    localparam int F_RATE_HI  = 1;
    localparam int F_RATE_LO  = 0;
    // Zero enable register
    localparam int F_BZ_HI    = 2;
    localparam int F_BZ_LO    = 1;
    localparam int F_PCM_ZERO_ENABLE     = 0;
    // Zero status register
    localparam int F_ZR       = 1;
    localparam int F_ZL       = 0;

    // Reset values
    localparam logic [3:0] RST_FILTER_CTRL = 4'h0;
    localparam logic [5:0] RST_MODE_SEL    = 6'h00;
    localparam logic [2:0] RST_ZERO_EN     = 3'h1;

    // Modulator rate encodings
    localparam logic [1:0] RATE_64X  = 2'h0;
    localparam logic [1:0] RATE_32X  = 2'h1;
    localparam logic [1:0] RATE_128X = 2'h2;

    // Bitstream zero pattern encodings
    localparam logic [1:0] BZ_OFF  = 2'h0;
    localparam logic [1:0] BZ_EVEN = 2'h1;

    // Sample routing selection
    typedef enum logic [1:0] {
        DMC_SRC_PCM,
        DMC_SRC_PARALLEL,
        DMC_SRC_BITSTREAM_PAIR
    } dmc_src_t;
endpackage

// >>> testbench/dmc_regs_props.sv
/*
 Checker for the mode-control bank, bound onto the top module's ports.
 Assumes all watched ports belong to the clk domain.
*/
module dmc_regs_props (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              left_zero_det,
    input wire logic              right_zero_det,
    input wire logic              right_zero_pin,
    input wire logic              system_reset,
    input wire logic              analog_mute,
    input wire logic              bitstream_mode,
    input wire logic              filter_bypass,
    input wire logic              single_channel_mode,
    input wire logic [1:0]        modulator_rate,
    input wire dmc_pkg::dmc_src_t sample_source
);
    timeunit 1ns;
    timeprecision 1ps;
    import dmc_pkg::*;
    // One clock domain; reset disables all but the reset check itself
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    reset_state_a:
        assert property (disable iff (1'b0) !rstn |=> !system_reset
            && !bitstream_mode && !analog_mute)
        else $error("outputs not cleared by reset");
    single_pulse_a:
        assert property (system_reset |=> !system_reset)
        else $error("soft reset pulse too long");
    soft_reset_restore_a:
        assert property ($rose(system_reset) |-> ##[1:4] !bitstream_mode
            && !filter_bypass && !single_channel_mode)
        else $error("soft reset left modes set");
    no_mute_bitstream_a:
        assert property (bitstream_mode && $past(bitstream_mode)
            |-> !analog_mute)
        else $error("mute applied in bitstream mode");
    mute_cause_a:
        assert property ($rose(analog_mute)
            |-> ($past(left_zero_det) && $past(right_zero_det))
            || ($past(left_zero_det, 2) && $past(right_zero_det, 2)))
        else $error("mute without zero on both channels");
    bitstream_rate_a:
        assert property (bitstream_mode && $past(bitstream_mode)
            |-> modulator_rate == RATE_64X)
        else $error("rate field reached modulator in bitstream mode");
    source_bypass_a:
        assert property (sample_source != DMC_SRC_PCM
            |-> filter_bypass || $past(filter_bypass))
        else $error("bypass routing without bypass mode");
    right_flag_quiet_a:
        assert property (!right_zero_det [*4] |=> !right_zero_pin)
        else $error("right zero flag without zero");
endmodule // dmc_regs_props

// >>> testbench/dmc_host.sv
/*
 Host model for the serial control port: 16-bit frames, MSB first.
 Assumes the bench calls xfer; the port clock idles low between frames.
*/
module dmc_host (
    output logic      port_clk,
    output logic      port_sel_n,
    output logic      port_din,
    input  wire logic port_dout,
    input  wire logic left_zero_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        port_clk = 1'b0;
        port_sel_n = 1'b1;
        port_din = 1'b0;
    end
    // Readback is sampled late in each cell since it crosses into clk
    task automatic xfer(input logic [15:0] w, output logic [7:0] rd,
                        output logic [7:0] ec);
        #13 port_sel_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            port_din = w[i];
            #80 port_clk = 1'b1;
            #79;
            if (i < 8) begin
                rd[i] = port_dout;
                ec[i] = left_zero_pin;
            end
            #1 port_clk = 1'b0;
        end
        #80 port_sel_n = 1'b1;
        port_din = ~w[0];
        #400;
    endtask
endmodule // dmc_host

// >>> testbench/tb_dmc_regs.sv
/*
 Bench for the mode-control bank: host frames via the serial model,
 datapath inputs driven at the falling clk edge.
 Assumes package, design, checker and host model are compiled first.
*/
module tb_dmc_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import dmc_pkg::*;
    logic       clk, rstn, port_clk, port_sel_n, port_din, port_dout;
    logic       port_dout_oe_n, left_zero_det, right_zero_det;
    logic       in_bitstream_sel, left_zero_pin, right_zero_pin;
    logic       system_reset, rolloff_select, analog_mute, bitstream_mode;
    logic       filter_bypass, single_channel_mode, single_channel_source;
    logic [1:0] modulator_rate, bitstream_clock_rate, bitstream_zero_select;
    dmc_src_t   sample_source;
    logic [7:0] rd, ec;
    logic [1:0] codes [3] = '{RATE_64X, RATE_32X, RATE_128X};
    int         fails = 0, tests_run = 0, cycles = 0, pulses = 0;

    // Identifier value is arbitrary
    dmc_regs #(.LINK_ID(5'h15)) DUT (.clk, .rstn, .port_clk, .port_sel_n,
        .port_din, .port_dout, .port_dout_oe_n, .left_zero_det,
        .right_zero_det, .in_bitstream_sel, .left_zero_pin, .right_zero_pin,
        .system_reset, .rolloff_select, .analog_mute, .bitstream_mode,
        .filter_bypass, .single_channel_mode, .single_channel_source,
        .modulator_rate, .bitstream_clock_rate, .bitstream_zero_select,
        .sample_source);
    dmc_host host (.port_clk, .port_sel_n, .port_din, .port_dout,
        .left_zero_pin);

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Watchdog well above the 32 frames; also counts reset pulses
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (system_reset === 1'b1) pulses <= pulses + 1;
        if (cycles == 12000) begin
            fails++;
            test_done();
        end
    end

    task automatic chk_reg(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_out(string n, logic [1:0] e, logic [1:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    // Ten cycles cover the crossing plus the output register
    task automatic wr(logic [6:0] idx, logic [7:0] d);
        host.xfer({1'b0, idx, d}, rd, ec);
        repeat (10) @(negedge clk);
    endtask
    task automatic rdr(logic [6:0] idx, logic [7:0] e, string n);
        host.xfer({1'b1, idx, 8'h00}, rd, ec);
        @(negedge clk);
        chk_reg(n, e, rd);
    endtask
    task automatic zeros(logic l, logic r);
        left_zero_det = l;
        right_zero_det = r;
        repeat (6) @(negedge clk);
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        in_bitstream_sel = 1'b0;
        zeros(1'b0, 1'b0);
        repeat (14) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        chk_out("oe_n", 2'h1, {1'b0, port_dout_oe_n});
        rdr(IDX_FILTER_CTRL, 8'h00, "ctrl");
        rdr(IDX_MODE_SEL, 8'h00, "mode");
        rdr(IDX_ZERO_EN, 8'h01, "zero_en");
        rdr(IDX_ZERO_STAT, 8'h00, "status");
        rdr(IDX_LINK_ID, 8'h15, "id");
        $display("test reset values done");
        // Every legal rate, with the reserved top bit set to be dropped
        foreach (codes[i]) begin
            wr(IDX_MODE_SEL, 8'h9C | codes[i]);
            chk_out("rate", codes[i], modulator_rate);
            rdr(IDX_MODE_SEL, 8'h1C | codes[i], "mode");
        end
        chk_out("single_channel_mode", 2'h1, {1'b0, single_channel_mode});
        chk_out("single_channel_mode_src", 2'h1, {1'b0, single_channel_source});
        chk_out("bypass", 2'h1, {1'b0, filter_bypass});
        chk_out("source", DMC_SRC_PARALLEL, sample_source);
        wr(IDX_FILTER_CTRL, 8'h06);
        chk_out("source", DMC_SRC_BITSTREAM_PAIR, sample_source);
        chk_out("rolloff", 2'h1, {1'b0, rolloff_select});
        $display("test mode fields done");
        // Mute needs both channels; status ignores writes
        wr(IDX_MODE_SEL, 8'h00);
        wr(IDX_FILTER_CTRL, 8'h01);
        zeros(1'b1, 1'b1);
        chk_out("mute", 2'h1, {1'b0, analog_mute});
        chk_out("pins", 2'h3, {left_zero_pin, right_zero_pin});
        wr(IDX_ZERO_STAT, 8'h00);
        rdr(IDX_ZERO_STAT, 8'h03, "status");
        zeros(1'b1, 1'b0);
        chk_out("mute", 2'h0, {1'b0, analog_mute});
        rdr(IDX_ZERO_STAT, 8'h01, "status");
        wr(IDX_ZERO_EN, 8'h00);
        chk_out("pins", 2'h0, {left_zero_pin, right_zero_pin});
        $display("test zero flags done");
        // Bitstream mode: no mute, rate field drives the bit clock
        zeros(1'b1, 1'b1);
        wr(IDX_MODE_SEL, 8'h22);
        chk_out("bitstream", 2'h1, {1'b0, bitstream_mode});
        chk_out("mute", 2'h0, {1'b0, analog_mute});
        chk_out("bit_clock", RATE_128X, bitstream_clock_rate);
        foreach (codes[i]) begin
            wr(IDX_ZERO_EN, {5'h1F, codes[i], 1'b0});
            chk_out("bz", codes[i], bitstream_zero_select);
            rdr(IDX_ZERO_EN, {5'h00, codes[i], 1'b0}, "zero_en");
        end
        $display("test bitstream done");
        // Soft reset pulses once per write and restores defaults
        wr(IDX_MODE_SEL, 8'h40);
        rdr(IDX_MODE_SEL, 8'h00, "mode");
        rdr(IDX_ZERO_EN, 8'h01, "zero_en");
        wr(IDX_MODE_SEL, 8'h40);
        chk_out("pulses", 2'h2, pulses[1:0]);
        zeros(1'b0, 1'b0);
        rdr(IDX_LINK_ID, 8'h15, "id");
        chk_reg("echo", 8'h00, ec);
        wr(IDX_FILTER_CTRL, 8'h08);
        rdr(IDX_LINK_ID, 8'h15, "id");
        chk_reg("echo", 8'h15, ec);
        $display("test soft reset and echo done");
        test_done();
    end
endmodule // tb_dmc_regs

bind dmc_regs dmc_regs_props u_props (.clk, .rstn, .left_zero_det,
    .right_zero_det, .right_zero_pin, .system_reset, .analog_mute,
    .bitstream_mode, .filter_bypass, .single_channel_mode,
    .modulator_rate, .sample_source);
